// file: design/npm_pkg.sv
package npm_pkg;

	// ==========================================
	// Timing
	// ==========================================
	localparam int unsigned CLK_HZ       = 40000000;  // Fast clock rate
	localparam int unsigned IDLE_TIME_US = 100;        // Near-term idle threshold
	localparam int unsigned IDLE_CYC     = (IDLE_TIME_US * (CLK_HZ / 1000000));
	localparam int unsigned BOOT_CYC     = 64;         // Cold boot length in cycles
	localparam int unsigned WAKE_CYC     = 8;          // Deep sleep wake latency
	localparam int unsigned CNT_W        = 16;         // Counter width

	// ==========================================
	// Modes
	// ==========================================
	// Subsystem mode
	typedef enum logic [1:0] {
		SUB_OFF,
		SUB_SLEEP,
		SUB_ACTIVE
	} npm_sub_t;

	// Microcontroller mode
	typedef enum logic [1:0] {
		MCU_HIB   = 2'h0,
		MCU_DEEP  = 2'h1,
		MCU_SLEEP = 2'h2,
		MCU_RUN   = 2'h3
	} npm_mcu_t;

	// Chip mode
	typedef enum logic [1:0] {
		CHIP_HIB   = 2'h0,
		CHIP_DEEP  = 2'h1,
		CHIP_ACT   = 2'h2
	} npm_chip_t;

	// Per-block state
	typedef enum logic [1:0] {
		BLK_OFF,
		BLK_RUN,
		BLK_RET,
		BLK_WAKE
	} npm_blk_t;

endpackage

// file: design/npm_blk_if.sv
`timescale 1ns/1ps
// Link between the sequencer and one block tracker
interface npm_blk_if;
	logic enable;   // Block powered (subsystem enabled and cold boot done)
	logic busy;     // Block has pending activity
	logic holdOff;  // Sleep forbidden (pending interrupt)
	logic lowPower; // Block is in retention

	modport ctl (output enable, output busy, output holdOff, input lowPower);
	modport blk (input enable, input busy, input holdOff, output lowPower);
endinterface

// file: design/npm_blk_sleep.sv
`timescale 1ns/1ps
// Own sleep/wake manager for one block
module npm_blk_sleep
	import npm_pkg::*;
#(
	parameter int unsigned IDLE = IDLE_CYC,
	parameter int unsigned WAKE = WAKE_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Sequencer side
	npm_blk_if.blk    port
);

	// ==========================================
	// State
	// ==========================================
	typedef struct packed {
		npm_blk_t         st;   // Block state
		logic [CNT_W-1:0] cnt;  // Idle or wake counter
	} npm_bs_t;

	npm_bs_t s_q;  // Registered state
	npm_bs_t s_d;  // Next state

	// Next-state logic
	always_comb begin
		s_d = s_q;
		if (!port.enable) begin
			s_d.st  = BLK_OFF;
			s_d.cnt = '0;
		end else begin
			unique case (s_q.st)
				BLK_OFF: begin
					s_d.st  = BLK_RUN;
					s_d.cnt = '0;
				end
				BLK_RUN: begin
					// Sleep only after a full idle period, never with irq up
					if (port.busy || port.holdOff) begin
						s_d.cnt = '0;
					end else if (s_q.cnt >= CNT_W'(IDLE - 1)) begin
						s_d.st  = BLK_RET;
						s_d.cnt = '0;
					end else begin
						s_d.cnt = s_q.cnt + 1'b1;
					end
				end
				BLK_RET: begin
					// Activity wakes the block by itself
					if (port.busy || port.holdOff) begin
						s_d.st  = BLK_WAKE;
						s_d.cnt = '0;
					end
				end
				BLK_WAKE: begin
					if (s_q.cnt >= CNT_W'(WAKE - 1)) begin
						s_d.st  = BLK_RUN;
						s_d.cnt = '0;
					end else begin
						s_d.cnt = s_q.cnt + 1'b1;
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '{st: BLK_OFF, cnt: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign port.lowPower = (s_q.st == BLK_RET);

endmodule

// file: design/npm_power_fsm.sv
`timescale 1ns/1ps
// How it works
// - Hibernate: memories lost, only hibernate logic, RTC
// - Deep sleep: low supply, fast clocks off, retention
// - Each block sleeps and wakes independently
// - Active whenever either block runs
// - Disabled means both off, enable cold boots
// - Integrated chip deep sleep gates logic; MCU restarts
// - Chip mode from MCU and subsystem modes
// - MCU sleep gates core clocks, chip active
// - Enable request brings immediate active cold boot
// - Boot end raises irq until status read
// - Sleep decided internally, never shown to host
// - Block sleeps only after idle threshold
// - Command while sleeping wakes processor block
// - No deep sleep while irq asserted
// - Irq drops once host reads status
module npm_power_fsm
	import npm_pkg::*;
#(
	parameter int unsigned BOOT = BOOT_CYC,
	parameter int unsigned IDLE = IDLE_CYC,
	parameter int unsigned WAKE = WAKE_CYC
) (
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      rst_n,
	// Host side
	input  wire logic      hibCtl,        // Hibernate control pin, high enables
	input  wire logic      procEnable,    // Internal enable register bit
	input  wire logic      integrated,    // High in the integrated variant
	input  wire logic      stopCmd,       // Stop command pulse
	input  wire logic      stopExpire,    // Host stop timeout has expired
	input  wire logic      hostCmd,       // Host command pulse
	input  wire logic      statusRead,    // Host read of status or event
	input  wire logic      eventPend,     // Internal event for the host
	output logic           hostIrq,       // Interrupt line to host
	// Activity inputs
	input  wire logic      procBusy,      // Processor block activity
	input  wire logic      radioBusy,     // Wireless block activity
	// Microcontroller
	input  npm_mcu_t       mcuMode,       // Microcontroller power mode
	output logic           mcuClkGate,    // Core clocks gated
	output logic           mcuRestart,    // Restart from reset vector pulse
	// Power controls
	output npm_sub_t       subMode,       // Subsystem mode
	output npm_chip_t      chipMode,      // Chip mode
	output logic           supplyLow,     // Supply levels lowered
	output logic           fastClkOn,     // Crystal and PLL running
	output logic           memRetain,     // Memories in retention
	output logic           memPowered,    // Memories powered
	output logic           logicGated,    // Main logic power-gated
	output logic           coldBoot,      // Cold boot in progress
	output logic           rtcOn          // Real-time clock running
);

	// ==========================================
	// Block trackers
	// ==========================================
	npm_blk_if procIf ();  // Processor block link
	npm_blk_if radioIf (); // Wireless block link

	// Top-level state
	typedef struct packed {
		npm_sub_t         sub;       // Subsystem mode
		logic             booting;   // Cold boot in progress
		logic [CNT_W-1:0] bootCnt;   // Boot counter
		logic             stopping;  // Stop command received
		logic             irq;       // Interrupt line
		logic             cmdPend;   // Host command pending
		npm_chip_t        chip;      // Chip mode
		logic             clkGate;   // Core clock gate
		logic             restart;   // Restart pulse
		logic             supLow;    // Supply lowered
		logic             fastOn;    // Fast clocks on
		logic             retain;    // Retention
		logic             memOn;     // Memory powered
		logic             gated;     // Logic gated
		logic             rtc;       // Real-time clock running
	} npm_st_t;

	npm_st_t s_q;   // Registered state
	npm_st_t s_d;   // Next state
	logic    enReq; // Enable request from pin or register

	// Chip mode table
	function automatic npm_chip_t chipOf(input npm_mcu_t m, input npm_sub_t s);
		unique case (m)
			MCU_HIB:  chipOf = CHIP_HIB;  // Only legal with subsystem off
			MCU_DEEP: chipOf = (s == SUB_ACTIVE) ? CHIP_ACT : CHIP_DEEP;
			default:  chipOf = CHIP_ACT;
		endcase
	endfunction

	// Discrete variant: no controller, so the chip simply follows the subsystem
	function automatic npm_chip_t subChipOf(input npm_sub_t s);
		unique case (s)
			SUB_OFF:   subChipOf = CHIP_HIB;
			SUB_SLEEP: subChipOf = CHIP_DEEP;
			default:   subChipOf = CHIP_ACT;
		endcase
	endfunction

	assign enReq = integrated ? procEnable : hibCtl;

	// Block activity and hold-off
	assign procIf.enable   = (s_q.sub != SUB_OFF) && !s_q.booting;
	assign radioIf.enable  = (s_q.sub != SUB_OFF) && !s_q.booting;
	assign procIf.busy     = procBusy || s_q.cmdPend;
	assign radioIf.busy    = radioBusy;
	assign procIf.holdOff  = s_q.irq;
	assign radioIf.holdOff = s_q.irq;

	// Processor block tracker
	npm_blk_sleep #(.IDLE(IDLE), .WAKE(WAKE)) uProc (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (procIf)
	);

	// Wireless block tracker
	npm_blk_sleep #(.IDLE(IDLE), .WAKE(WAKE)) uRadio (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (radioIf)
	);

	// ==========================================
	// Next-state logic
	// ==========================================
	always_comb begin
		s_d = s_q;
		s_d.restart = 1'b0;
		// Command pending until processor block leaves retention
		if (hostCmd && s_q.sub != SUB_OFF) begin
			s_d.cmdPend = 1'b1;
		end else if (!procIf.lowPower) begin
			s_d.cmdPend = 1'b0;
		end
		unique case (s_q.sub)
			SUB_OFF: begin
				s_d.irq      = 1'b0;
				s_d.stopping = 1'b0;
				s_d.cmdPend  = 1'b0;
				// An expired stop keeps the subsystem down even with enable high
				if (enReq && !stopExpire) begin
					s_d.sub     = SUB_ACTIVE;
					s_d.booting = 1'b1;
					s_d.bootCnt = '0;
				end
			end
			default: begin
				if (stopCmd) begin
					s_d.stopping = 1'b1;
				end
				if (stopExpire || (s_q.stopping && !enReq) || !enReq) begin
					s_d.sub     = SUB_OFF;
					s_d.booting = 1'b0;
					s_d.irq     = 1'b0;     // Nothing left to signal once off
				end else begin
					// Boot finished raises irq; event or read handled here
					if (s_q.booting) begin
						if (s_q.bootCnt >= CNT_W'(BOOT - 1)) begin
							s_d.booting = 1'b0;
							s_d.irq     = 1'b1;
						end else begin
							s_d.bootCnt = s_q.bootCnt + 1'b1;
						end
					end else if (eventPend) begin
						s_d.irq = 1'b1;  // Set wins over clear
					end else if (statusRead) begin
						s_d.irq = 1'b0;
					end
					// Deep sleep only when both blocks retain
					// Next irq value blocks entry in the very cycle it is raised
					if (!s_q.booting && !s_d.irq && procIf.lowPower && radioIf.lowPower) begin
						s_d.sub = SUB_SLEEP;
					end else begin
						s_d.sub = SUB_ACTIVE;
					end
				end
			end
		endcase
		// Chip mode and power controls
		s_d.chip    = integrated ? chipOf(mcuMode, s_d.sub) : subChipOf(s_d.sub);
		s_d.rtc     = 1'b1;
		s_d.clkGate = (mcuMode == MCU_SLEEP);
		if (s_q.chip == CHIP_DEEP && s_d.chip != CHIP_DEEP && integrated) begin
			s_d.restart = 1'b1;
		end
		s_d.fastOn = (s_d.chip == CHIP_ACT);
		s_d.supLow = (s_d.chip != CHIP_ACT);
		s_d.retain = (s_d.chip == CHIP_DEEP);
		s_d.memOn  = (s_d.chip != CHIP_HIB);
		s_d.gated  = (s_d.chip == CHIP_HIB) ||
		             (integrated && s_d.chip == CHIP_DEEP);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '{sub: SUB_OFF, booting: 1'b0, bootCnt: '0, stopping: 1'b0,
			         irq: 1'b0, cmdPend: 1'b0, chip: CHIP_HIB, clkGate: 1'b0,
			         restart: 1'b0, supLow: 1'b1, fastOn: 1'b0, retain: 1'b0,
			         memOn: 1'b0, gated: 1'b1, rtc: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs
	// ==========================================
	assign hostIrq    = s_q.irq;
	assign mcuClkGate = s_q.clkGate;
	assign mcuRestart = s_q.restart;
	assign subMode    = s_q.sub;
	assign chipMode   = s_q.chip;
	assign supplyLow  = s_q.supLow;
	assign fastClkOn  = s_q.fastOn;
	assign memRetain  = s_q.retain;
	assign memPowered = s_q.memOn;
	assign logicGated = s_q.gated;
	assign coldBoot   = s_q.booting;
	assign rtcOn      = s_q.rtc;

endmodule

// file: bench/npm_host_model.sv
`timescale 1ns/1ps
// Host side: answers the interrupt line by reading status
module npm_host_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Service link
	input  wire logic hostIrq,
	input  int        svcDelay,
	output logic      statusRead
);
	int waitCnt; // Cycles the line has been seen high

	// Read once the service delay runs out; one-cycle strobe
	always_ff @(posedge clk) begin
		if (!rst_n || !hostIrq || statusRead) begin
			waitCnt    <= 0;
			statusRead <= 1'b0;
		end else if (waitCnt >= svcDelay) begin
			statusRead <= 1'b1;
		end else begin
			waitCnt <= waitCnt + 1;
		end
	end
endmodule

// file: bench/npm_power_fsm_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the power sequencer
module npm_power_fsm_asserts
	import npm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host side
	input wire logic hibCtl,
	input wire logic procEnable,
	input wire logic integrated,
	input wire logic stopExpire,
	input wire logic statusRead,
	input wire logic eventPend,
	input wire logic hostIrq,
	// Modes and power controls
	input npm_mcu_t  mcuMode,
	input npm_sub_t  subMode,
	input npm_chip_t chipMode,
	input wire logic mcuClkGate,
	input wire logic supplyLow,
	input wire logic fastClkOn,
	input wire logic memRetain,
	input wire logic memPowered,
	input wire logic coldBoot,
	input wire logic rtcOn
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic enReq; // Enable from the selected source
	assign enReq = integrated ? procEnable : hibCtl;

	// ==========================================
	// Assertions
	// ==========================================
	chk_hib_mem_off: assert property (subMode == SUB_OFF && chipMode == CHIP_HIB |->
		!memPowered && rtcOn) else $error("hibernate keeps memory powered");
	chk_sleep_power: assert property (chipMode == CHIP_DEEP |->
		supplyLow && !fastClkOn && memRetain) else $error("deep sleep power wrong");
	chk_active_power: assert property (subMode == SUB_ACTIVE |->
		!supplyLow && fastClkOn) else $error("active power wrong");
	chk_enable_boot: assert property (subMode == SUB_OFF && enReq && !stopExpire |=>
		subMode == SUB_ACTIVE && coldBoot) else $error("enable did not boot");
	chk_stay_off: assert property (subMode == SUB_OFF && !enReq |=>
		subMode == SUB_OFF) else $error("left off without enable");
	chk_expire_off: assert property (stopExpire |=> subMode == SUB_OFF)
		else $error("timeout did not disable");
	chk_boot_irq: assert property ($fell(coldBoot) && subMode == SUB_ACTIVE |->
		hostIrq) else $error("boot end without interrupt");
	chk_irq_drop: assert property (hostIrq && statusRead && !eventPend |=>
		!hostIrq) else $error("interrupt kept after read");
	chk_no_irq_sleep: assert property (subMode == SUB_SLEEP |->
		!hostIrq) else $error("slept with interrupt high");
	chk_chip_active: assert property ($past(rst_n) && $past(integrated) &&
		$past(mcuMode) inside {MCU_SLEEP, MCU_RUN} |-> chipMode == CHIP_ACT)
		else $error("chip mode not active");
	chk_core_gate: assert property ($past(rst_n) && $past(mcuMode) == MCU_SLEEP |->
		mcuClkGate) else $error("core clocks not gated");
endmodule

bind npm_power_fsm npm_power_fsm_asserts npm_power_fsm_asserts_i (.clk(clk), .rst_n(rst_n),
	.hibCtl(hibCtl), .procEnable(procEnable), .integrated(integrated), .stopExpire(stopExpire),
	.statusRead(statusRead), .eventPend(eventPend), .hostIrq(hostIrq), .mcuMode(mcuMode),
	.subMode(subMode), .chipMode(chipMode), .mcuClkGate(mcuClkGate), .supplyLow(supplyLow),
	.fastClkOn(fastClkOn), .memRetain(memRetain), .memPowered(memPowered),
	.coldBoot(coldBoot), .rtcOn(rtcOn));

// file: bench/test_network_power_mode_fsm.sv
`timescale 1ns/1ps
module test_network_power_mode_fsm;
	import npm_pkg::*;
	localparam int BOOT = 16; // Shortened boot
	localparam int IDLE = 8;  // Shortened idle threshold
	localparam int WAKE = 8;  // Wake latency
	// Stimulus
	logic clk, rst_n, hibCtl, procEnable, integrated, stopCmd, stopExpire;
	logic hostCmd, statusRead, eventPend, procBusy, radioBusy;
	npm_mcu_t mcuMode;
	// Observed outputs
	logic hostIrq, mcuClkGate, mcuRestart, supplyLow, fastClkOn, memRetain;
	logic memPowered, logicGated, coldBoot, rtcOn;
	npm_sub_t  subMode;
	npm_chip_t chipMode;
	int num_errors, samples_checked, cycles, svcDelay, i, n;

	npm_power_fsm #(.BOOT(BOOT), .IDLE(IDLE), .WAKE(WAKE)) npm_power_fsm_i (.clk(clk),
		.rst_n(rst_n), .hibCtl(hibCtl), .procEnable(procEnable), .integrated(integrated),
		.stopCmd(stopCmd), .stopExpire(stopExpire), .hostCmd(hostCmd), .statusRead(statusRead),
		.eventPend(eventPend), .hostIrq(hostIrq), .procBusy(procBusy), .radioBusy(radioBusy),
		.mcuMode(mcuMode), .mcuClkGate(mcuClkGate), .mcuRestart(mcuRestart), .subMode(subMode),
		.chipMode(chipMode), .supplyLow(supplyLow), .fastClkOn(fastClkOn), .memRetain(memRetain),
		.memPowered(memPowered), .logicGated(logicGated), .coldBoot(coldBoot), .rtcOn(rtcOn));
	npm_host_model npm_host_model_i (.clk(clk), .rst_n(rst_n), .hostIrq(hostIrq),
		.svcDelay(svcDelay), .statusRead(statusRead));

	// Reference chip mode from controller and subsystem modes
	function automatic int expChip(int mcu, int sub);
		if (mcu == 0) return 0;
		if (mcu >= 2 || sub == 2) return 2;
		return 1;
	endfunction

	// One comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask

	// Step past k edges, landing just after the last
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Count edges until the subsystem mode matches, bounded
	task automatic waitSub(input npm_sub_t m);
		n = 0;
		while (subMode !== m && n < 200) begin
			cyc(1);
			n++;
		end
	endtask

	// Counts and verdict
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		{rst_n, hibCtl, procEnable, integrated, stopCmd, stopExpire} = '0;
		{hostCmd, eventPend, procBusy, radioBusy} = '0;
		mcuMode = MCU_RUN;
		svcDelay = 3;
		void'($urandom(32'hf226));
		cyc(4);
		rst_n = 1'b1;
		cyc(3);
		chk(subMode, SUB_OFF, "off after reset");
		chk(memPowered, 0, "memory off after reset");
		chk(rtcOn, 1, "rtc runs");
		hibCtl = 1'b1;
		cyc(1);
		chk(subMode, SUB_ACTIVE, "enable");
		chk(coldBoot, 1, "cold boot");
		n = 0;
		while (!hostIrq && n < 200) begin
			cyc(1);
			n++;
		end
		chk(n, BOOT, "boot length");
		waitSub(SUB_SLEEP);
		chk(n >= IDLE, 1, "idle threshold");
		chk({supplyLow, fastClkOn, memRetain}, 3'b101, "sleep power");
		procEnable = 1'b1;
		integrated = 1'b1;
		for (i = 1; i < 4; i++) begin
			mcuMode = npm_mcu_t'(i);
			cyc(1);
			chk(mcuRestart, i == 2, "restart on wake");
			cyc(1);
			chk(chipMode, expChip(i, 1), "chip mode");
			chk(mcuClkGate, i == 2, "core gate");
			chk(logicGated, i == 1, "logic gated");
		end
		hostCmd = 1'b1;
		cyc(1);
		hostCmd = 1'b0;
		waitSub(SUB_ACTIVE);
		chk(n <= WAKE + 1, 1, "wake on command");
		for (i = 0; i < 30; i++) begin
			radioBusy = 1'($urandom_range(0, 1));
			procBusy = 1'($urandom_range(0, 1));
			cyc(1);
		end
		radioBusy = 1'b1;
		cyc(2);
		chk(subMode, SUB_ACTIVE, "busy active");
		{radioBusy, procBusy} = '0;
		svcDelay = 5 * IDLE;
		eventPend = 1'b1;
		cyc(1);
		eventPend = 1'b0;
		waitSub(SUB_SLEEP);
		chk(n > 4 * IDLE, 1, "no sleep with irq");
		mcuMode = MCU_DEEP;
		stopCmd = 1'b1;
		cyc(1);
		stopCmd = 1'b0;
		procEnable = 1'b0;
		cyc(1);
		chk(subMode, SUB_OFF, "stop then drop");
		cyc(1);
		chk(chipMode, expChip(1, 0), "chip deep");
		integrated = 1'b1;
		procEnable = 1'b1;
		cyc(1);
		chk(subMode, SUB_ACTIVE, "register enable");
		stopExpire = 1'b1;
		cyc(1);
		stopExpire = 1'b0;
		procEnable = 1'b0;
		chk(subMode, SUB_OFF, "forced off");
		integrated = 1'b0;
		cyc(1);
		chk(subMode, SUB_ACTIVE, "pin enable");
		stopCmd = 1'b1;
		cyc(1);
		stopCmd = 1'b0;
		hibCtl = 1'b0;
		cyc(1);
		chk(subMode, SUB_OFF, "stop then drop pin");
		chk(chipMode, CHIP_HIB, "chip hibernate");
		chk(memPowered, 0, "memory off");
		cyc(3);
		end_of_test();
	end
endmodule
